// file: logic/rpss_pkg.sv
// constants for the rmii strap and pin sharing block
package rpss_pkg;
  // shared push-pull pin indexes
  localparam int unsigned SHR_W      = 5;
  localparam int unsigned SHR_RXD1   = 0;
  localparam int unsigned SHR_RXD0   = 1;
  localparam int unsigned SHR_CRSDV  = 2;
  localparam int unsigned SHR_REFCLK = 3;
  localparam int unsigned SHR_RXER   = 4;
  // strap synchroniser lanes
  localparam int unsigned STP_W      = 10;
  localparam int unsigned STP_AD0    = 0;
  localparam int unsigned STP_AD1    = 1;
  localparam int unsigned STP_MODE0  = 2;
  localparam int unsigned STP_MODE1  = 3;
  localparam int unsigned STP_SHR    = 4;
  localparam int unsigned STP_IRQ    = 9;
  // link synchroniser lanes
  localparam int unsigned LNK_W      = 5;
  localparam int unsigned LNK_TXEN   = 0;
  localparam int unsigned LNK_TXD0   = 1;
  localparam int unsigned LNK_TXD1   = 2;
  localparam int unsigned LNK_MDC    = 3;
  localparam int unsigned LNK_MDIO   = 4;
  // address and reset values
  localparam logic [1:0] ADDR_UPPER_RST = 2'h0;
  localparam logic [4:0] ADDR_BCAST     = 5'h00;
  localparam logic [4:0] ADDR_RST       = 5'h00;
  localparam logic [2:0] MODE_RST       = 3'h0;
  // sync depth plus filter register, in cycles
  localparam int unsigned SYNC_LAT_CYC  = 4;
  localparam logic [2:0]  SETTLE_LAST   = 3'(SYNC_LAT_CYC);
  typedef enum logic [1:0] {
    ST_SETTLE = 2'b01,
    ST_RUN    = 2'b10
  } rpss_state_e;
endpackage : rpss_pkg

// file: logic/rpss_pin_if.sv
// interface between pin synchroniser and core
`timescale 1ns/10ps
interface rpss_pin_if #(parameter int unsigned W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] filt;
  modport sync (input raw, output filt);
  modport core (output raw, input filt);
endinterface : rpss_pin_if

// file: logic/rpss_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module rpss_sync3 (
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  input  wire logic ce_in,
  rpss_pin_if.sync  pins
);
  localparam int unsigned W = $bits(pins.raw);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] filt_q;
  wire  [W-1:0] agree_w = ~(s2_q ^ s3_q);
  wire  [W-1:0] filt_d  = (agree_w & s2_q) | (~agree_w & filt_q);
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
    end else if (ce_in) begin
      s1_q   <= pins.raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end
  assign pins.filt = filt_q;
endmodule : rpss_sync3

// file: logic/rpss_refclk_gen.sv
// glitch-free gated rmii reference clock output
`timescale 1ns/10ps
module rpss_refclk_gen (
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  input  wire logic ce_in,
  input  wire logic en_in,
  output wire logic ref_clk_out
);
  logic en_q;
  // enable moves only while the clock is low
  always_ff @(negedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_q <= 1'b0;
    end else if (ce_in) begin
      en_q <= en_in;
    end
  end
  assign ref_clk_out = ref_clk_in & en_q;
endmodule : rpss_refclk_gen

// file: logic/rpss_core.sv
// rmii phy strap capture and shared pin control
//
// Function
// - strap pins input in reset, output after
// - latch three address straps as address bits
// - latch rxd0 pin as full/half select
// - latch crs_dv and mode pins as mode
// - latch refclk pin as broadcast disable
// - latch rxer pin as detach, isolating mac
// - latch irq pin as active-low chain test
// - drive rxd1 rxd0 crs_dv rxer after reset
// - 25 MHz mode drives 50 MHz refclk out
// - mdc rise samples mdio in; mdio drive follows the low request, not mdc
// - mdio open drain, low or released
// - interrupt open drain, low when asserted
// - upper two address bits default zero
// - address zero broadcast unless disable strapped
// - chain test enabled only by low strap
`timescale 1ns/10ps
module rpss_core
  import rpss_pkg::*;
(
  input  wire logic             ref_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic             ce_in,
  input  wire logic             osc_25m_mode_in,
  input  wire logic             phy_addr_strap_bit0_in,
  input  wire logic             phy_addr_strap_bit1_in,
  input  wire logic             mode_strap_bit0_in,
  input  wire logic             mode_strap_bit1_in,
  input  wire logic [SHR_W-1:0] shr_pin_in,
  output wire logic [SHR_W-1:0] shr_pin_out,
  output wire logic [SHR_W-1:0] shr_pin_oe_out,
  input  wire logic             irq_pin_in,
  output wire logic             irq_out,
  output wire logic             irq_oe_out,
  input  wire logic             irq_req_in,
  input  wire logic [1:0]       rx_data_in,
  input  wire logic             rx_crs_dv_in,
  input  wire logic             rx_err_in,
  input  wire logic             tx_en_pin_in,
  input  wire logic [1:0]       tx_data_pin_in,
  output wire logic             tx_en_out,
  output wire logic [1:0]       tx_data_out,
  input  wire logic             mdc_pin_in,
  input  wire logic             mdio_pin_in,
  output wire logic             mdio_out,
  output wire logic             mdio_oe_out,
  input  wire logic             mgmt_drive_low_in,
  output wire logic             mdc_rise_out,
  output wire logic             mdio_bit_out,
  input  wire logic [4:0]       mgmt_addr_in,
  output wire logic             addr_match_out,
  output wire logic [4:0]       phy_mgmt_address_out,
  output wire logic             full_half_select_out,
  output wire logic [2:0]       mode_strap_out,
  output wire logic             broadcast_disable_out,
  output wire logic             detach_out,
  output wire logic             pin_chain_test_en_out,
  output wire logic             strap_valid_out
);
  // ************************************************
  // pin synchronisers
  // ************************************************
  rpss_pin_if #(.W(STP_W)) stp_if ();
  rpss_pin_if #(.W(LNK_W)) lnk_if ();
  assign stp_if.raw = {irq_pin_in, shr_pin_in, mode_strap_bit1_in,
                       mode_strap_bit0_in, phy_addr_strap_bit1_in,
                       phy_addr_strap_bit0_in};
  assign lnk_if.raw = {mdio_pin_in, mdc_pin_in, tx_data_pin_in, tx_en_pin_in};
  rpss_sync3 u_stp_sync (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .ce_in      (ce_in),
    .pins       (stp_if.sync)
  );
  rpss_sync3 u_lnk_sync (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .ce_in      (ce_in),
    .pins       (lnk_if.sync)
  );
  wire [STP_W-1:0] stp_w = stp_if.filt;
  wire [LNK_W-1:0] lnk_w = lnk_if.filt;
  wire [SHR_W-1:0] shr_w = stp_w[STP_SHR +: SHR_W];

  // ************************************************
  // settle and capture sequencer
  // ************************************************
  rpss_state_e state_q;
  rpss_state_e state_d;
  logic [2:0]  cnt_q;
  logic [2:0]  cnt_d;
  wire         run_w     = (state_q == ST_RUN);
  // capture one edge after the filter output settles
  wire         capture_w = (state_q == ST_SETTLE) && (cnt_q == SETTLE_LAST);
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_SETTLE: begin
        cnt_d = cnt_q + 3'h1;
        if (capture_w) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        cnt_d = cnt_q;
      end
      default: begin
        state_d = ST_SETTLE;
        cnt_d   = 3'h0;
      end
    endcase
  end
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_SETTLE;
      cnt_q   <= 3'h0;
    end else if (ce_in) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ************************************************
  // strap registers
  // ************************************************
  logic [2:0] addr_q;
  logic       fh_q;
  logic [2:0] mode_q;
  logic       bcast_dis_q;
  logic       detach_q;
  logic       chain_n_q;
  // loaded once, then held to next reset
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      addr_q      <= ADDR_RST[2:0];
      fh_q        <= 1'b0;
      mode_q      <= MODE_RST;
      bcast_dis_q <= 1'b0;
      detach_q    <= 1'b0;
      chain_n_q   <= 1'b1;
    end else if (ce_in && capture_w) begin
      addr_q      <= {shr_w[SHR_RXD1], stp_w[STP_AD1], stp_w[STP_AD0]};
      fh_q        <= shr_w[SHR_RXD0];
      mode_q      <= {shr_w[SHR_CRSDV], stp_w[STP_MODE1], stp_w[STP_MODE0]};
      bcast_dis_q <= shr_w[SHR_REFCLK];
      detach_q    <= shr_w[SHR_RXER];
      chain_n_q   <= stp_w[STP_IRQ];
    end
  end
  wire [4:0] addr_w = {ADDR_UPPER_RST, addr_q};
  assign phy_mgmt_address_out  = addr_w;
  assign full_half_select_out  = fh_q;
  assign mode_strap_out        = mode_q;
  assign broadcast_disable_out = bcast_dis_q;
  assign detach_out            = detach_q;
  assign pin_chain_test_en_out = ~chain_n_q;
  assign strap_valid_out       = run_w;
  // broadcast address answers unless disabled
  wire bcast_hit_w = (mgmt_addr_in == ADDR_BCAST) && !bcast_dis_q;
  assign addr_match_out = run_w && ((mgmt_addr_in == addr_w) || bcast_hit_w);

  // ************************************************
  // rmii receive pins and reference clock
  // ************************************************
  logic [3:0] rx_q;
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_q <= 4'h0;
    end else if (ce_in) begin
      rx_q <= {rx_err_in, rx_crs_dv_in, rx_data_in[0], rx_data_in[1]};
    end
  end
  wire drive_w  = run_w && !detach_q;
  wire refclk_w;
  rpss_refclk_gen u_refclk (
    .ref_clk_in  (ref_clk_in),
    .arst_n_in   (arst_n_in),
    .ce_in       (ce_in),
    .en_in       (drive_w && osc_25m_mode_in),
    .ref_clk_out (refclk_w)
  );
  assign shr_pin_out = {rx_q[3], refclk_w, rx_q[2:0]};
  // straps are inputs until settle ends
  assign shr_pin_oe_out = {drive_w, drive_w && osc_25m_mode_in,
                           drive_w, drive_w, drive_w};

  // ************************************************
  // transmit inputs and management pins
  // ************************************************
  logic [2:0] tx_q;
  logic       mdc_q;
  logic       mdc_rise_q;
  logic       mdio_q;
  wire        mdc_rise_w = lnk_w[LNK_MDC] && !mdc_q;
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_q       <= 3'h0;
      mdc_q      <= 1'b0;
      mdc_rise_q <= 1'b0;
      mdio_q     <= 1'b0;
    end else if (ce_in) begin
      tx_q       <= drive_w ? lnk_w[LNK_TXD1:LNK_TXEN] : 3'h0;
      mdc_q      <= lnk_w[LNK_MDC];
      mdc_rise_q <= mdc_rise_w;
      if (mdc_rise_w) begin
        mdio_q <= lnk_w[LNK_MDIO];
      end
    end
  end
  assign tx_en_out    = tx_q[0];
  assign tx_data_out  = tx_q[2:1];
  assign mdc_rise_out = mdc_rise_q;
  assign mdio_bit_out = mdio_q;
  assign mdio_out     = 1'b0;
  assign mdio_oe_out  = run_w && mgmt_drive_low_in;
  assign irq_out      = 1'b0;
  assign irq_oe_out   = run_w && irq_req_in;

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [2:0] stp_addr_w;
  assign stp_addr_w = {shr_w[SHR_RXD1], stp_w[STP_AD1], stp_w[STP_AD0]};
  AST_INPUT_IN_RESET: assert property (
    !run_w |-> (shr_pin_oe_out == '0) && !irq_oe_out && !mdio_oe_out)
    else $error("strap pin driven before capture");
  AST_ADDR_CAPTURE: assert property (
    $rose(run_w) |-> (addr_q == $past(stp_addr_w)))
    else $error("address straps not captured");
  AST_DUPLEX_CAPTURE: assert property (
    $rose(run_w) |-> (fh_q == $past(shr_w[SHR_RXD0])))
    else $error("full/half strap not captured");
  AST_MODE_CAPTURE: assert property (
    $rose(run_w) |-> (mode_q == $past({shr_w[SHR_CRSDV], stp_w[STP_MODE1], stp_w[STP_MODE0]})))
    else $error("mode straps not captured");
  AST_BCAST_CAPTURE: assert property (
    $rose(run_w) |-> (bcast_dis_q == $past(shr_w[SHR_REFCLK])))
    else $error("broadcast strap not captured");
  AST_DETACH_ISOLATE: assert property (
    detach_q |-> (shr_pin_oe_out == '0) && !tx_en_out)
    else $error("detached device drives mac side");
  AST_CHAIN_CAPTURE: assert property (
    $rose(run_w) |-> (pin_chain_test_en_out == !$past(stp_w[STP_IRQ])))
    else $error("chain test strap wrong");
  AST_RX_DRIVE: assert property (
    run_w && ce_in ##1 drive_w |-> (shr_pin_out[SHR_RXD1] == $past(rx_data_in[1]))
      && (shr_pin_out[SHR_RXER] == $past(rx_err_in)) && shr_pin_oe_out[SHR_RXER])
    else $error("rmii receive pins not driven");
  AST_REFCLK_OE: assert property (
    shr_pin_oe_out[SHR_REFCLK] == (drive_w && osc_25m_mode_in))
    else $error("reference clock drive wrong");
  AST_MDIO_OD: assert property (
    mdio_oe_out |-> !mdio_out)
    else $error("mdio driven high");
  AST_IRQ_OD: assert property (
    run_w && irq_req_in |-> irq_oe_out && !irq_out)
    else $error("interrupt not pulled low");
  AST_ADDR_UPPER: assert property (
    phy_mgmt_address_out[4:3] == 2'h0)
    else $error("upper address bits set");
  AST_BCAST_MATCH: assert property (
    run_w && (mgmt_addr_in == 5'h00) |-> (addr_match_out == (!bcast_dis_q || addr_q == 3'h0)))
    else $error("broadcast address match wrong");
  AST_STRAP_HOLD: assert property (
    run_w && $past(run_w) |-> $stable({addr_q, fh_q, mode_q, bcast_dis_q, detach_q, chain_n_q}))
    else $error("strap values changed after capture");
  AST_MDC_SAMPLE: assert property (
    ce_in && mdc_rise_w |=> mdio_bit_out == $past(lnk_w[LNK_MDIO]))
    else $error("mdio not sampled on mdc rise");
  AST_TX_QUIET: assert property (
    ce_in && !drive_w |=> !tx_en_out && (tx_data_out == 2'h0))
    else $error("transmit outputs not held at zero");
  AST_TX_MAP: assert property (
    ce_in && drive_w |=> ({tx_data_out, tx_en_out} == $past(lnk_w[LNK_TXD1:LNK_TXEN])))
    else $error("transmit pins not passed through");
  AST_MDIO_REQ: assert property (
    run_w && mgmt_drive_low_in |-> mdio_oe_out && !mdio_out)
    else $error("mdio not pulled low on request");
  AST_IRQ_RELEASE: assert property (
    !irq_req_in |-> !irq_oe_out)
    else $error("interrupt pin held without request");
  AST_VALID_STEADY: assert property (
    run_w |=> run_w)
    else $error("strap valid dropped before reset");
  // clock enable low freezes every register
  AST_CE_FREEZE: assert property (
    !ce_in |=> $stable({state_q, cnt_q, rx_q, tx_q, mdio_q}))
    else $error("state moved while clock enable low");
  COV_CAPTURE: cover property ($rose(run_w));
  COV_BCAST: cover property (run_w && bcast_hit_w);
  COV_DETACH: cover property (run_w && detach_q);
  COV_MDC: cover property (mdc_rise_q ##1 mdio_oe_out);
  COV_REFCLK: cover property (shr_pin_oe_out[SHR_REFCLK] ##1 !osc_25m_mode_in);
endmodule : rpss_core

// file: tb/rpss_mac_model.sv
// far-side model: rmii mac, management station and strap resistors
`timescale 1ns/10ps
module rpss_mac_model (
  input  wire logic       ref_clk_in,
  input  wire logic [4:0] shr_pull_in,
  input  wire logic       irq_pull_in,
  input  wire logic [4:0] shr_drv_in,
  input  wire logic [4:0] shr_oe_in,
  input  wire logic       irq_oe_in,
  input  wire logic       mdio_oe_in,
  input  wire logic       mdc_run_in,
  input  wire logic       st_bit_in,
  input  wire logic [2:0] tx_req_in,
  output wire logic [4:0] shr_lvl_out,
  output wire logic       irq_lvl_out,
  output wire logic       mdc_out,
  output wire logic       mdio_out,
  output wire logic [2:0] tx_pin_out
);
  // ****************************************
  // pin levels, clocks and transmit drive
  // ****************************************
  logic [2:0] div_q = 3'h0;
  logic       mdc_q = 1'b0;
  logic [2:0] tx_q  = 3'h0;
  // released shared pins settle at their strap resistor level
  assign shr_lvl_out = (shr_oe_in & shr_drv_in) | (~shr_oe_in & shr_pull_in);
  assign irq_lvl_out = irq_oe_in ? 1'b0 : irq_pull_in;
  // open drain: either party pulls low, else pull-up
  assign mdio_out    = (mdio_oe_in | ~st_bit_in) ? 1'b0 : 1'b1;
  assign mdc_out     = mdc_q;
  assign tx_pin_out  = tx_q;
  always_ff @(posedge ref_clk_in) begin
    div_q <= div_q + 3'h1;
    tx_q  <= tx_req_in;
    // mdc still when idle, half period eight cycles
    if (!mdc_run_in) begin
      mdc_q <= 1'b0;
    end else if (div_q == 3'h7) begin
      mdc_q <= ~mdc_q;
    end
  end
endmodule : rpss_mac_model

// file: tb/testbench.sv
// self-checking bench for the strap and pin sharing core
`timescale 1ns/10ps
module testbench;
  import rpss_pkg::*;
  typedef struct packed {
    logic [9:0] straps;
    logic [4:0] addr;
    logic [2:0] mode;
    logic [3:0] flags;
  } rpss_row_s;
  // straps {irq, m1, m0, shr[4:0], ad1, ad0}; flags {fh, bc, det, chain}
  rpss_row_s rows [4] = '{'{10'h000, 5'h00, 3'h0, 4'h1}, '{10'h3FF, 5'h07, 3'h7, 4'hE},
                          '{10'h329, 5'h01, 3'h2, 4'hC}, '{10'h096, 5'h06, 3'h5, 4'h1}};
  logic       ref_clk_in, arst_n_in, ce, osc_25m, irq_req, mgmt_low, mdc_run, st_bit, rx_crs, rx_err;
  logic [9:0] straps;
  logic [1:0] rx_data;
  logic [2:0] tx_req;
  logic [4:0] mgmt_addr;
  wire  [4:0] shr_lvl, shr_out, shr_oe, addr;
  wire  [2:0] tx_pin, mode;
  wire  [1:0] tx_d_o;
  wire        irq_pin, irq_o, irq_oe, mdc, mdio, mdio_o, mdio_oe, mdc_rise, mdio_bit, match, tx_en_o;
  wire        fh, bc, det, chain, valid;
  int         mismatches = 0;
  int         checks = 0;
  int         i;
  rpss_core uut (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .ce_in(ce), .osc_25m_mode_in(osc_25m),
    .phy_addr_strap_bit0_in(straps[0]), .phy_addr_strap_bit1_in(straps[1]), .mode_strap_bit0_in(straps[7]),
    .mode_strap_bit1_in(straps[8]), .shr_pin_in(shr_lvl), .shr_pin_out(shr_out), .shr_pin_oe_out(shr_oe),
    .irq_pin_in(irq_pin), .irq_out(irq_o), .irq_oe_out(irq_oe), .irq_req_in(irq_req), .rx_data_in(rx_data),
    .rx_crs_dv_in(rx_crs), .rx_err_in(rx_err), .tx_en_pin_in(tx_pin[0]), .tx_data_pin_in(tx_pin[2:1]),
    .tx_en_out(tx_en_o), .tx_data_out(tx_d_o), .mdc_pin_in(mdc), .mdio_pin_in(mdio), .mdio_out(mdio_o),
    .mdio_oe_out(mdio_oe), .mgmt_drive_low_in(mgmt_low), .mdc_rise_out(mdc_rise), .mdio_bit_out(mdio_bit),
    .mgmt_addr_in(mgmt_addr), .addr_match_out(match), .phy_mgmt_address_out(addr), .full_half_select_out(fh),
    .mode_strap_out(mode), .broadcast_disable_out(bc), .detach_out(det), .pin_chain_test_en_out(chain),
    .strap_valid_out(valid));
  rpss_mac_model mac (
    .ref_clk_in(ref_clk_in), .shr_pull_in(straps[6:2]), .irq_pull_in(straps[9]), .shr_drv_in(shr_out),
    .shr_oe_in(shr_oe), .irq_oe_in(irq_oe), .mdio_oe_in(mdio_oe), .mdc_run_in(mdc_run), .st_bit_in(st_bit),
    .tx_req_in(tx_req), .shr_lvl_out(shr_lvl), .irq_lvl_out(irq_pin), .mdc_out(mdc), .mdio_out(mdio),
    .tx_pin_out(tx_pin));
  // ****************************************
  // helpers
  // ****************************************
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic sel(input int k);
    return k == 0 ? valid : (k == 1 ? tx_en_o : mdc_rise);
  endfunction : sel
  task automatic wait_hi(input int k);
    int n;
    for (n = 0; n < 40 && sel(k) !== 1'b1; n++) @(negedge ref_clk_in);
    chk(8'(sel(k)), 8'h1);
    if (sel(k) !== 1'b1) complete_run();
  endtask : wait_hi
  task automatic do_reset(input logic [9:0] v);
    @(posedge ref_clk_in);
    arst_n_in <= 1'b0;
    straps    <= v;
    repeat (5) @(posedge ref_clk_in);
    chk({2'h0, shr_oe, valid}, 8'h00);
    arst_n_in <= 1'b1;
    wait_hi(0);
  endtask : do_reset
  // ****************************************
  // stimulus
  // ****************************************
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    {arst_n_in, osc_25m, irq_req, mgmt_low, mdc_run, st_bit, rx_crs, rx_err, ce} = 9'h089;
    {straps, rx_data, tx_req, mgmt_addr} = 20'h00000;
    for (i = 0; i < 4; i++) begin
      do_reset(rows[i].straps);
      chk(8'(addr), 8'(rows[i].addr));
      chk(8'(mode), 8'(rows[i].mode));
      chk({4'h0, fh, bc, det, chain}, 8'(rows[i].flags));
      chk(8'(shr_oe & 5'h17), rows[i].flags[1] ? 8'h00 : 8'h17);
      chk(8'(match), 8'(!rows[i].flags[2] || rows[i].addr == 5'h00));
    end
    // later pin activity must not disturb captured values
    @(posedge ref_clk_in);
    straps <= ~straps;
    repeat (8) @(negedge ref_clk_in);
    chk({addr, mode}, {5'h06, 3'h5});
    chk({6'h0, chain, bc}, 8'h2);
    for (i = 0; i < 3; i++) begin
      @(posedge ref_clk_in);
      mgmt_addr <= i == 0 ? 5'h00 : (i == 1 ? 5'h06 : 5'h05);
      @(negedge ref_clk_in);
      chk(8'(match), 8'(i < 2));
    end
    for (i = 0; i < 2; i++) begin
      @(posedge ref_clk_in);
      {rx_err, rx_crs, rx_data} <= i ? 4'h9 : 4'h6;
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      chk(8'(shr_out & 5'h17), i ? 8'h12 : 8'h05);
    end
    // clock enable low must freeze the receive drive
    @(posedge ref_clk_in);
    ce <= 1'b0;
    {rx_err, rx_crs, rx_data} <= 4'h6;
    repeat (2) @(negedge ref_clk_in);
    chk(8'(shr_out & 5'h17), 8'h12);
    @(posedge ref_clk_in);
    ce <= 1'b1;
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk(8'(shr_out & 5'h17), 8'h05);
    chk(8'(shr_oe[SHR_REFCLK]), 8'h1);
    @(posedge ref_clk_in);
    #5;
    chk(8'(shr_out[SHR_REFCLK]), 8'h1);
    @(negedge ref_clk_in);
    #5;
    chk(8'(shr_out[SHR_REFCLK]), 8'h0);
    @(posedge ref_clk_in);
    osc_25m <= 1'b0;
    repeat (3) @(negedge ref_clk_in);
    chk(8'(shr_oe[SHR_REFCLK]), 8'h0);
    @(posedge ref_clk_in);
    tx_req <= 3'h5;
    wait_hi(1);
    chk(8'(tx_d_o), 8'h2);
    @(posedge ref_clk_in);
    mdc_run <= 1'b1;
    wait_hi(2);
    chk(8'(mdio_bit), 8'h1);
    @(posedge ref_clk_in);
    mgmt_low <= 1'b1;
    @(negedge ref_clk_in);
    chk({6'h0, mdio_oe, mdio_o}, 8'h2);
    wait_hi(2);
    chk(8'(mdio_bit), 8'h0);
    @(posedge ref_clk_in);
    {mgmt_low, mdc_run, irq_req} <= 3'h1;
    @(negedge ref_clk_in);
    chk({5'h0, irq_oe, irq_o, irq_pin}, 8'h4);
    @(posedge ref_clk_in);
    irq_req <= 1'b0;
    @(negedge ref_clk_in);
    chk({5'h0, irq_oe, mdio_oe, irq_pin}, 8'h1);
    complete_run();
  end
endmodule : testbench
